// File: hw/contactor_seq_pkg.sv
// Purpose: Shared constants and types for the contactor and servo sequencer
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Delay register counts i_clk cycles of 5 ns
package contactor_seq_pkg;
  localparam int          NUM_AXES        = 4;
  localparam int          COORD_AXIS      = 0;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          DELAY_W         = 16;
  localparam int          IRQ_W           = 3;

  // Register byte offsets
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  STATUS_OFS      = 8'h04;
  localparam logic [7:0]  IRQ_STAT_OFS    = 8'h08;
  localparam logic [7:0]  IRQ_MASK_OFS    = 8'h0C;
  localparam logic [7:0]  DELAY_OFS       = 8'h10;

  // Control fields
  localparam int          CTRL_DRIVE_EN   = 0;
  localparam int          CTRL_READY_ON   = 1;
  localparam int          CTRL_STARTUP    = 2;
  localparam int          CTRL_W          = 3;
  localparam logic [2:0]  CTRL_RESET      = 3'h0;

  // Status fields
  localparam int          STAT_CONTACTOR  = 0;
  localparam int          STAT_EXT_CTRL   = 1;
  localparam int          STAT_BASE_LSB   = 8;
  localparam int          STAT_BRAKE_LSB  = 12;
  localparam int          STAT_POS_LSB    = 16;

  // Interrupt event bits
  localparam int          IRQ_CONT_OPEN   = 0;
  localparam int          IRQ_COORD_OFF   = 1;
  localparam int          IRQ_BASE_OFF    = 2;
  localparam logic [2:0]  IRQ_RESET       = 3'h0;

  localparam logic [15:0] DELAY_RESET     = 16'h0000;
  localparam logic [15:0] DELAY_ONE       = 16'h0001;
  localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

  typedef enum logic [1:0] {
    AX_OFF  = 2'b00,
    AX_RUN  = 2'b01,
    AX_HOLD = 2'b10
  } axis_state_t;
endpackage

// File: hw/contactor_servo_sequencer.sv
// Purpose: Contactor, brake interlock and base circuit sequencing for several axes
// Assumes: Servo-on inputs synchronous to i_clk; axis COORD_AXIS is the coordinated one
// Notes:   APB registers, zero wait states, level interrupt
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module contactor_servo_sequencer (
  // Clock and reset
  input  wire logic                                      i_clk,
  input  wire logic                                      i_rstn,
  // APB slave
  input  wire logic                                      i_psel,
  input  wire logic                                      i_penable,
  input  wire logic                                      i_pwrite,
  input  wire logic [contactor_seq_pkg::ADDR_W-1:0]      i_paddr,
  input  wire logic [contactor_seq_pkg::DATA_W-1:0]      i_pwdata,
  output logic      [contactor_seq_pkg::DATA_W-1:0]      o_prdata,
  output logic                                           o_pready,
  output logic                                           o_pslverr,
  // Controller and drives
  input  wire logic [contactor_seq_pkg::NUM_AXES-1:0]    i_servo_on,
  output logic                                           o_contactor,
  output logic                                           o_ext_ctrl,
  output logic      [contactor_seq_pkg::NUM_AXES-1:0]    o_base_on,
  output logic      [contactor_seq_pkg::NUM_AXES-1:0]    o_brake_release_interlock,
  output logic      [contactor_seq_pkg::NUM_AXES-1:0]    o_pos_cmd_ok,
  // Interrupt
  output logic                                           o_irq
);
  import contactor_seq_pkg::*;

  logic [CTRL_W-1:0]   ctrl_reg;
  logic [CTRL_W-1:0]   ctrl_next;
  logic [IRQ_W-1:0]    irq_stat_reg;
  logic [IRQ_W-1:0]    irq_stat_next;
  logic [IRQ_W-1:0]    irq_mask_reg;
  logic [IRQ_W-1:0]    irq_mask_next;
  logic [DELAY_W-1:0]  delay_reg;
  logic [DELAY_W-1:0]  delay_next;
  logic [DATA_W-1:0]   prdata_reg;
  logic [DATA_W-1:0]   prdata_next;
  logic                contactor_reg;
  logic                contactor_next;
  logic                coord_q_reg;
  logic                coord_q_next;
  logic [NUM_AXES-1:0] servo_eff;
  logic [NUM_AXES-1:0] base_next_w;
  logic [NUM_AXES-1:0] brake_next_w;
  logic [IRQ_W-1:0]    events;
  logic                drive_en;
  logic                ready_on;
  logic                startup_done;
  logic                wr_access;
  logic                mapped;
  logic [DATA_W-1:0]   rd_mux;
  logic [DATA_W-1:0]   status_word;

  assign drive_en     = ctrl_reg[CTRL_DRIVE_EN];
  assign ready_on     = ctrl_reg[CTRL_READY_ON];
  assign startup_done = ctrl_reg[CTRL_STARTUP];
  // Servo-on has no effect before startup
  assign servo_eff    = startup_done ? i_servo_on : '0;

  // APB decode: reads latched in setup, writes land in the access cycle
  always_comb begin
    mapped = (i_paddr == CTRL_OFS) || (i_paddr == STATUS_OFS) ||
             (i_paddr == IRQ_STAT_OFS) || (i_paddr == IRQ_MASK_OFS) ||
             (i_paddr == DELAY_OFS);
    status_word = WORD_ZERO;
    status_word[STAT_CONTACTOR] = contactor_reg;
    status_word[STAT_EXT_CTRL]  = o_ext_ctrl;
    status_word[STAT_BASE_LSB +: NUM_AXES]  = o_base_on;
    status_word[STAT_BRAKE_LSB +: NUM_AXES] = o_brake_release_interlock;
    status_word[STAT_POS_LSB +: NUM_AXES]   = o_pos_cmd_ok;
    rd_mux = WORD_ZERO;
    unique case (i_paddr)
      CTRL_OFS:     rd_mux[CTRL_W-1:0]  = ctrl_reg;
      STATUS_OFS:   rd_mux              = status_word;
      IRQ_STAT_OFS: rd_mux[IRQ_W-1:0]   = irq_stat_reg;
      IRQ_MASK_OFS: rd_mux[IRQ_W-1:0]   = irq_mask_reg;
      DELAY_OFS:    rd_mux[DELAY_W-1:0] = delay_reg;
      default:      rd_mux              = WORD_ZERO;
    endcase
  end

  assign wr_access = i_psel && i_penable && i_pwrite && mapped;
  assign o_pready  = i_psel && i_penable;
  assign o_pslverr = i_psel && i_penable && !mapped;
  assign o_prdata  = prdata_reg;

  always_comb begin
    prdata_next   = prdata_reg;
    ctrl_next     = ctrl_reg;
    irq_mask_next = irq_mask_reg;
    delay_next    = delay_reg;
    if (i_psel && !i_penable && !i_pwrite) begin
      prdata_next = rd_mux;
    end
    if (wr_access && i_paddr == CTRL_OFS) begin
      ctrl_next = i_pwdata[CTRL_W-1:0];
      // Startup completes once; only reset clears it
      ctrl_next[CTRL_STARTUP] = startup_done | i_pwdata[CTRL_STARTUP];
    end
    if (wr_access && i_paddr == IRQ_MASK_OFS) begin
      irq_mask_next = i_pwdata[IRQ_W-1:0];
    end
    if (wr_access && i_paddr == DELAY_OFS) begin
      delay_next = i_pwdata[DELAY_W-1:0];
    end
  end

  // Contactor decision; only the coordinated axis can open it
  always_comb begin
    contactor_next = 1'b0;
    if (drive_en && startup_done) begin
      if (ready_on) begin
        contactor_next = 1'b1;
      end else begin
        contactor_next = servo_eff[COORD_AXIS];
      end
    end
    coord_q_next = servo_eff[COORD_AXIS];
  end

  // Drive disabled hands the contactor to outside alarm logic
  assign o_ext_ctrl  = !drive_en;
  assign o_contactor = contactor_reg;

  // Sticky events, set wins over write-one-clear
  always_comb begin
    events = '0;
    events[IRQ_CONT_OPEN] = contactor_reg && !contactor_next;
    events[IRQ_COORD_OFF] = coord_q_reg && !servo_eff[COORD_AXIS];
    events[IRQ_BASE_OFF]  = |(o_base_on & ~base_next_w);
    irq_stat_next = irq_stat_reg;
    if (wr_access && i_paddr == IRQ_STAT_OFS) begin
      irq_stat_next = irq_stat_reg & ~i_pwdata[IRQ_W-1:0];
    end
    irq_stat_next = irq_stat_next | events;
  end

  assign o_irq = |(irq_stat_reg & irq_mask_reg);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ctrl_reg      <= CTRL_RESET;
      irq_stat_reg  <= IRQ_RESET;
      irq_mask_reg  <= IRQ_RESET;
      delay_reg     <= DELAY_RESET;
      prdata_reg    <= WORD_ZERO;
      contactor_reg <= 1'b0;
      coord_q_reg   <= 1'b0;
    end else begin
      ctrl_reg      <= ctrl_next;
      irq_stat_reg  <= irq_stat_next;
      irq_mask_reg  <= irq_mask_next;
      delay_reg     <= delay_next;
      prdata_reg    <= prdata_next;
      contactor_reg <= contactor_next;
      coord_q_reg   <= coord_q_next;
    end
  end

  // Per-axis brake and base sequencing
  genvar k;
  generate
    for (k = 0; k < NUM_AXES; k++) begin : g_axis
      axis_state_t        state_reg;
      axis_state_t        state_next;
      logic [DELAY_W-1:0] cnt_reg;
      logic [DELAY_W-1:0] cnt_next;

      always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        unique case (state_reg)
          AX_OFF: begin
            if (servo_eff[k]) begin
              state_next = AX_RUN;
            end
          end
          AX_RUN: begin
            if (!servo_eff[k]) begin
              if (ready_on && delay_reg != DELAY_RESET) begin
                // Brake engages first, base holds torque for the delay
                state_next = AX_HOLD;
                cnt_next   = delay_reg - DELAY_ONE;
              end else begin
                state_next = AX_OFF;
              end
            end
          end
          AX_HOLD: begin
            if (cnt_reg == DELAY_RESET) begin
              state_next = AX_OFF;
            end else begin
              cnt_next = cnt_reg - DELAY_ONE;
            end
          end
          default: begin
            state_next = AX_OFF;
          end
        endcase
      end

      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          state_reg <= AX_OFF;
          cnt_reg   <= DELAY_RESET;
        end else begin
          state_reg <= state_next;
          cnt_reg   <= cnt_next;
        end
      end

      assign base_next_w[k]  = (state_next != AX_OFF);
      assign brake_next_w[k] = (state_next == AX_RUN);
      assign o_base_on[k]    = (state_reg != AX_OFF);
      // High level releases the brake
      assign o_brake_release_interlock[k] = (state_reg == AX_RUN);
      // Position commands only once brake is released
      assign o_pos_cmd_ok[k] = (state_reg == AX_RUN);

      sequence s_drop_ready_on;
        state_reg == AX_RUN && !servo_eff[k] && ready_on && delay_reg != DELAY_RESET;
      endsequence

      sequence s_drop_ready_off;
        state_reg == AX_RUN && !servo_eff[k] && !ready_on;
      endsequence

      property p_hold_then_off;
        @(posedge i_clk) disable iff (!i_rstn)
        (s_drop_ready_on and (delay_reg == DELAY_ONE)) |=>
          (o_base_on[k] && !o_brake_release_interlock[k]) ##1 !o_base_on[k];
      endproperty

      chk_base_delay_step: assert property (p_hold_then_off)
        else $error("base circuit delay after brake drop wrong");

      chk_hold_keeps_base: assert property (@(posedge i_clk) disable iff (!i_rstn)
        s_drop_ready_on |=> o_base_on[k] && !o_brake_release_interlock[k])
        else $error("base dropped before delay in ready-on");

      chk_ready_off_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
        s_drop_ready_off |=> !o_base_on[k] && !o_brake_release_interlock[k])
        else $error("ready-off servo-off did not cut base at once");

      chk_brake_under_base: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_brake_release_interlock[k] |-> o_base_on[k] && o_pos_cmd_ok[k])
        else $error("brake released without base circuit on");
    end
  endgenerate

  chk_startup_hold_off: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !startup_done |-> !o_contactor && o_base_on == '0)
    else $error("outputs active before startup completed");

  chk_ready_on_closed: assert property (@(posedge i_clk) disable iff (!i_rstn)
    drive_en && ready_on && startup_done |=> o_contactor)
    else $error("contactor opened in ready-on");

  chk_ready_off_open: assert property (@(posedge i_clk) disable iff (!i_rstn)
    drive_en && !ready_on && !servo_eff[COORD_AXIS] |=> !o_contactor)
    else $error("contactor stayed closed after coordinated servo-off");

  chk_other_axes_ignored: assert property (@(posedge i_clk) disable iff (!i_rstn)
    drive_en && !ready_on && servo_eff[COORD_AXIS] |=> o_contactor)
    else $error("contactor opened by an uncoordinated axis");

  chk_ext_no_drive: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_ext_ctrl |=> !o_contactor || !$past(o_ext_ctrl))
    else $error("contactor driven while drive output disabled");

  chk_open_event: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $fell(o_contactor) |-> irq_stat_reg[IRQ_CONT_OPEN])
    else $error("contactor opening not recorded");

  // Sticky bits must survive a clear written in the same cycle
  chk_set_wins_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
    events != '0 |=> (irq_stat_reg & $past(events)) == $past(events))
    else $error("interrupt event lost against a clear");

  chk_coord_off_event: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $past(i_rstn) && $fell(servo_eff[COORD_AXIS]) |=> irq_stat_reg[IRQ_COORD_OFF])
    else $error("coordinated servo-off not recorded");

  chk_base_off_event: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $past(i_rstn) && ($past(o_base_on) & ~o_base_on) != '0 |-> irq_stat_reg[IRQ_BASE_OFF])
    else $error("base circuit shutoff not recorded");

  chk_startup_sticky: assert property (@(posedge i_clk) disable iff (!i_rstn)
    startup_done |=> startup_done)
    else $error("startup flag cleared without reset");
endmodule // contactor_servo_sequencer
`default_nettype wire

// File: test/motion_ctrl_model.sv
// Purpose: Far-side model: controller, brake actuators, outside contactor logic
// Assumes: Servo requests come from the bench as levels
// Notes:   Outside contactor path only counts while the sequencer hands it over
`timescale 1ns/1ps
`default_nettype none
module motion_ctrl_model (
  // From bench
  input  wire logic       i_alarm,
  input  wire logic [3:0] i_servo_req,
  input  wire logic [3:0] i_move,
  // From sequencer
  input  wire logic       i_contactor,
  input  wire logic       i_ext_ctrl,
  input  wire logic [3:0] i_brake_release_interlock,
  input  wire logic [3:0] i_pos_cmd_ok,
  // Results
  output logic      [3:0] o_servo_on,
  output logic      [3:0] o_brake_engaged,
  output logic      [3:0] o_pos_cmd,
  output logic            o_mc_closed
);
  assign o_servo_on      = i_servo_req;
  assign o_brake_engaged = ~i_brake_release_interlock;
  // Commands held back while the brake still grips
  assign o_pos_cmd       = i_move & i_pos_cmd_ok & i_brake_release_interlock;
  assign o_mc_closed     = i_ext_ctrl ? ~i_alarm : i_contactor;
endmodule // motion_ctrl_model
`default_nettype wire

// File: test/test_contactor_servo_sequencer.sv
// Purpose: Self-checking bench for the contactor and servo sequencer
// Assumes: Zero wait state APB, axis 0 coordinated
// Notes:   One task per scenario
`timescale 1ns/1ps
`default_nettype none
module test_contactor_servo_sequencer;
  import contactor_seq_pkg::*;
  logic        i_clk = 1'b0, i_rstn = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
  logic        i_pwrite = 1'b0, alarm = 1'b0, o_pready, o_pslverr, o_contactor;
  logic        o_ext_ctrl, o_irq, mc_closed, last_err;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rdat;
  logic [3:0]  servo_req = 4'h0, move = 4'hF, i_servo_on, o_base_on;
  logic [3:0]  o_brake_release_interlock, o_pos_cmd_ok, brake_engaged, pos_cmd;
  int          n_fail = 0, num_checks = 0, cyc = 0;
  always #2.5 i_clk = ~i_clk;
  contactor_servo_sequencer i_contactor_servo_sequencer (.i_clk(i_clk),
    .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_servo_on(i_servo_on),
    .o_contactor(o_contactor), .o_ext_ctrl(o_ext_ctrl), .o_base_on(o_base_on),
    .o_brake_release_interlock(o_brake_release_interlock),
    .o_pos_cmd_ok(o_pos_cmd_ok), .o_irq(o_irq));
  motion_ctrl_model i_motion_ctrl_model (.i_alarm(alarm), .i_servo_req(servo_req),
    .i_move(move), .i_contactor(o_contactor), .i_ext_ctrl(o_ext_ctrl),
    .i_brake_release_interlock(o_brake_release_interlock),
    .i_pos_cmd_ok(o_pos_cmd_ok), .o_servo_on(i_servo_on),
    .o_brake_engaged(brake_engaged), .o_pos_cmd(pos_cmd), .o_mc_closed(mc_closed));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    // Wait ends when o_pready goes high; the bench hang guard ends it only if o_pready never comes
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    rdat = o_prdata;
    last_err = o_pslverr;
    i_psel <= 1'b0; i_penable <= 1'b0;
  endtask
  task automatic servo(input logic [3:0] v, input int n);
    @(posedge i_clk) servo_req <= v;
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic t_reset_regs;
    apb(1'b0, CTRL_OFS, 32'h0);      chk("ctrl", rdat, 32'h0);
    apb(1'b0, IRQ_MASK_OFS, 32'h0);  chk("mask", rdat, 32'h0);
    apb(1'b0, DELAY_OFS, 32'h0);     chk("delay", rdat, 32'h0);
    apb(1'b0, 8'h40, 32'h0);         chk("unmapped err", last_err, 1'b1);
    chk("unmapped rd", rdat, 32'h0);
    servo(4'hF, 3);
    chk("base pre-startup", o_base_on, 4'h0);
    chk("contactor pre-startup", o_contactor, 1'b0);
    $display("test reset_regs done");
  endtask
  task automatic t_ready_on;
    apb(1'b1, DELAY_OFS, 32'h3);
    apb(1'b1, CTRL_OFS, 32'h7);
    servo(4'hF, 2);
    chk("brake all released", o_brake_release_interlock, 4'hF);
    servo(4'hE, 1);
    chk("brake0 drop", o_brake_release_interlock, 4'hE);
    chk("brake0 engaged", brake_engaged, 4'h1);
    chk("pos cmd held", pos_cmd, 4'hE);
    chk("base held", o_base_on, 4'hF);
    repeat (2) @(posedge i_clk);
    #1 chk("base still on", o_base_on, 4'hF);
    @(posedge i_clk);
    #1 chk("base off after delay", o_base_on, 4'hE);
    chk("contactor kept", o_contactor, 1'b1);
    // Zero delay in ready-on: base drops with the brake
    apb(1'b1, DELAY_OFS, 32'h0);
    servo(4'hC, 1);
    chk("base zero delay", o_base_on, 4'hC);
    // Delay of one cycle: shortest hold
    apb(1'b1, DELAY_OFS, 32'h1);
    servo(4'hF, 2);
    servo(4'hD, 1);
    chk("base1 one-cycle hold", o_base_on, 4'hF);
    chk("brake1 one-cycle drop", o_brake_release_interlock, 4'hD);
    @(posedge i_clk);
    #1 chk("base1 off after one", o_base_on, 4'hD);
    $display("test ready_on done");
  endtask
  task automatic t_ready_off;
    servo(4'hF, 2);
    apb(1'b1, CTRL_OFS, 32'h5);
    apb(1'b1, IRQ_STAT_OFS, 32'h7);
    servo(4'hD, 1);
    chk("base1 with servo", o_base_on, 4'hD);
    chk("brake1 with servo", o_brake_release_interlock, 4'hD);
    @(posedge i_clk);
    #1 chk("contactor other axis", o_contactor, 1'b1);
    chk("irq masked", o_irq, 1'b0);
    servo(4'hC, 2);
    chk("contactor coord off", o_contactor, 1'b0);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status", rdat, 32'h000C_CC00);
    apb(1'b1, IRQ_MASK_OFS, 32'h1);
    #1 chk("irq raised", o_irq, 1'b1);
    apb(1'b1, IRQ_STAT_OFS, 32'h1);
    #1 chk("irq cleared", o_irq, 1'b0);
    apb(1'b0, IRQ_STAT_OFS, 32'h0);  chk("irq stat", rdat, 32'h6);
    $display("test ready_off done");
  endtask
  task automatic t_external;
    apb(1'b1, CTRL_OFS, 32'h4);
    servo(4'hF, 2);
    chk("ext ctrl", o_ext_ctrl, 1'b1);
    chk("own drive off", o_contactor, 1'b0);
    chk("outside closes", mc_closed, 1'b1);
    @(posedge i_clk) alarm <= 1'b1;
    #1 chk("alarm opens", mc_closed, 1'b0);
    $display("test external done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard well above the roughly 80 cycles needed
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_reset_regs();
    t_ready_on();
    t_ready_off();
    t_external();
    tally_and_finish();
  end
endmodule // test_contactor_servo_sequencer
`default_nettype wire
